// *** inc/irq_prio_pkg.sv ***
// Shared constants and carrier types for the interrupt prioritizer.
// Assumes one clock domain and an APB register port with 32-bit data.
package irq_prio_pkg;

  // Vector space; vector 0 is the reset entry and never requested
  localparam int              NUM_VEC      = 32;
  localparam int              VEC_W        = 5;
  localparam int              ADDR_W       = 16;
  localparam int              PADDR_W      = 12;

  // Register indices; byte address is four times the index
  localparam logic [1:0]      IDX_CTRL     = 2'h0;
  localparam logic [1:0]      IDX_STATUS   = 2'h1;
  localparam logic [1:0]      IDX_PRI      = 2'h2;
  localparam logic [1:0]      IDX_L1VEC    = 2'h3;

  // Field positions
  localparam int              CTRL_ROT_BIT  = 0;
  localparam int              CTRL_CVT_BIT  = 5;
  localparam int              CTRL_BASE_BIT = 6;
  localparam int              STAT_L0_BIT   = 0;
  localparam int              STAT_L1_BIT   = 1;
  localparam int              STAT_NMI_BIT  = 7;

  // Reset values
  localparam logic [7:0]      CTRL_RST     = 8'h00;
  localparam logic [7:0]      PRI_RST      = 8'h00;
  localparam logic [7:0]      L1VEC_RST    = 8'h00;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;

  // Vector table layout
  localparam logic [ADDR_W-1:0] VEC_OFFSET = 16'h0000;
  localparam int              VEC_SLOT_SH  = 1;
  localparam logic [VEC_W-1:0] CVT_NMI_VEC = 5'h01;
  localparam logic [VEC_W-1:0] CVT_L1_VEC  = 5'h02;
  localparam logic [VEC_W-1:0] CVT_L0_VEC  = 5'h03;

  // Lines wired as non-maskable in this device
  localparam logic [NUM_VEC-1:0] NMI_MASK  = 32'h0000_0002;

  // Program counter push takes this many cycles after the ack
  localparam logic [1:0]      PUSH_CYCLES  = 2'h2;

  typedef enum logic [1:0] {LVL_0, LVL_1, LVL_NMI} level_type;

  typedef struct packed {
    logic base_sel;
    logic compact;
    logic rotate;
  } ctrl_type;

  typedef struct packed {
    logic nmi_ex;
    logic l1_ex;
    logic l0_ex;
  } status_type;

  typedef struct packed {
    logic             valid;
    logic [VEC_W-1:0] vec;
    level_type        lvl;
  } pick_type;

endpackage

// *** hdl/irq_arbiter.sv ***
// Combinational ranking of requests into one winner.
// Assumes requests come from logic on the same clock.
`timescale 1ns/10ps
module irq_arbiter (
  input  wire logic [irq_prio_pkg::NUM_VEC-1:0] req,
  input  wire logic                             gie,
  input  wire logic                             rotate,
  input  wire logic [irq_prio_pkg::VEC_W-1:0]   l1_vec,
  input  wire logic [irq_prio_pkg::VEC_W-1:0]   last_l0,
  input  wire irq_prio_pkg::status_type         status,
  output irq_prio_pkg::pick_type                pick
);

  // First set bit at or after start, wrapping; bit 0 is never a request
  function automatic logic [irq_prio_pkg::VEC_W:0] first_from(
    input logic [irq_prio_pkg::NUM_VEC-1:0] bits,
    input logic [irq_prio_pkg::VEC_W-1:0]   start);
    logic [irq_prio_pkg::VEC_W-1:0] idx;
    logic [irq_prio_pkg::VEC_W:0]   res;
    res = '0;
    for (int i = irq_prio_pkg::NUM_VEC - 1; i >= 0; i--) begin
      idx = start + irq_prio_pkg::VEC_W'(i);
      if (bits[idx] && idx != '0) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  logic [irq_prio_pkg::NUM_VEC-1:0] nmi_req;
  logic [irq_prio_pkg::NUM_VEC-1:0] l0_req;
  logic [irq_prio_pkg::VEC_W:0]     nmi_hit;
  logic [irq_prio_pkg::VEC_W:0]     l0_hit;
  logic [irq_prio_pkg::VEC_W-1:0]   l0_start;
  logic                             l1_hit;

  always_comb begin
    nmi_req  = req & irq_prio_pkg::NMI_MASK;
    l0_req   = req & ~irq_prio_pkg::NMI_MASK;
    l0_req[l1_vec] = 1'b0;
    l1_hit   = req[l1_vec] && !irq_prio_pkg::NMI_MASK[l1_vec] && l1_vec != '0;
    l0_start = rotate ? last_l0 + 5'h01 : 5'h00;
    nmi_hit  = first_from(nmi_req, 5'h00);
    l0_hit   = first_from(l0_req, l0_start);
    pick     = '0;
    if (nmi_hit[irq_prio_pkg::VEC_W] && !status.nmi_ex) begin
      pick = '{1'b1, nmi_hit[irq_prio_pkg::VEC_W-1:0], irq_prio_pkg::LVL_NMI};
    end else if (gie && !status.nmi_ex && l1_hit && !status.l1_ex) begin
      pick = '{1'b1, l1_vec, irq_prio_pkg::LVL_1};
    end else if (gie && l0_hit[irq_prio_pkg::VEC_W] && status == '0) begin
      pick = '{1'b1, l0_hit[irq_prio_pkg::VEC_W-1:0], irq_prio_pkg::LVL_0};
    end
  end

endmodule

// *** hdl/vector_mapper.sv ***
// Combinational vector address from winner, table mode and base choice.
// Assumes the application start address is steady while running.
`timescale 1ns/10ps
module vector_mapper (
  input  wire logic [irq_prio_pkg::VEC_W-1:0]  vec,
  input  wire irq_prio_pkg::level_type         lvl,
  input  wire irq_prio_pkg::ctrl_type          ctrl,
  input  wire logic [irq_prio_pkg::ADDR_W-1:0] app_start,
  output logic      [irq_prio_pkg::ADDR_W-1:0] addr
);

  logic [irq_prio_pkg::VEC_W-1:0]  slot;
  logic [irq_prio_pkg::ADDR_W-1:0] base;

  always_comb begin
    slot = vec;
    if (ctrl.compact) begin
      case (lvl)
        irq_prio_pkg::LVL_NMI: slot = irq_prio_pkg::CVT_NMI_VEC;
        irq_prio_pkg::LVL_1:   slot = irq_prio_pkg::CVT_L1_VEC;
        default:               slot = irq_prio_pkg::CVT_L0_VEC;
      endcase
    end
    // Boot placement drops the application start
    base = ctrl.base_sel ? irq_prio_pkg::VEC_OFFSET : app_start + irq_prio_pkg::VEC_OFFSET;
    addr = base + (irq_prio_pkg::ADDR_W'(slot) << irq_prio_pkg::VEC_SLOT_SH);
  end

endmodule

// *** hdl/cpu_interrupt_prioritizer.sv ***
// Interrupt prioritizer between peripherals and a small core, APB registers.
// Assumes core handshakes (instruction end, return, halt) are on pclk.
`timescale 1ns/10ps
module cpu_interrupt_prioritizer (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [irq_prio_pkg::PADDR_W-1:0]  paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [irq_prio_pkg::NUM_VEC-1:0]  irq_req,
  input  wire logic                              global_int_enable,
  input  wire logic                              instr_done,
  input  wire logic                              return_from_handler,
  input  wire logic                              debug_halt,
  input  wire logic [irq_prio_pkg::ADDR_W-1:0]   app_start_addr,
  output logic                                   irq_ack,
  output logic      [irq_prio_pkg::VEC_W-1:0]    ack_vector,
  output logic                                   core_stall,
  output logic                                   pc_load,
  output logic      [irq_prio_pkg::ADDR_W-1:0]   pc_vector_addr,
  output logic      [irq_prio_pkg::ADDR_W-1:0]   reset_addr,
  output logic                                   nmi_executing,
  output logic                                   high_executing,
  output logic                                   low_executing
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PUSH, SEQ_LOAD} seq_type;

  typedef struct packed {
    seq_type                          seq;
    logic [1:0]                       push_cnt;
    logic                             gap_ok;
    irq_prio_pkg::ctrl_type           ctrl;
    irq_prio_pkg::status_type         status;
    logic [irq_prio_pkg::VEC_W-1:0]   l1_vec;
    logic [irq_prio_pkg::VEC_W-1:0]   last_l0;
    logic [irq_prio_pkg::ADDR_W-1:0]  vec_addr;
    logic [31:0]                      rdata;
    logic                             ready;
    logic                             err;
    logic                             ack;
    logic [irq_prio_pkg::VEC_W-1:0]   ack_vec;
    logic                             stall;
    logic                             load;
  } state_type;

  state_type state_ff;
  state_type nxt_state;

  irq_prio_pkg::pick_type          pick;
  logic [irq_prio_pkg::ADDR_W-1:0] pick_addr;
  logic                            access;
  logic                            addr_ok;
  logic [1:0]                      idx;

  irq_arbiter u_arbiter (
    .req     (irq_req),
    .gie     (global_int_enable),
    .rotate  (state_ff.ctrl.rotate),
    .l1_vec  (state_ff.l1_vec),
    .last_l0 (state_ff.last_l0),
    .status  (state_ff.status),
    .pick    (pick)
  );

  vector_mapper u_mapper (
    .vec       (pick.vec),
    .lvl       (pick.lvl),
    .ctrl      (state_ff.ctrl),
    .app_start (app_start_addr),
    .addr      (pick_addr)
  );

  // Register view of control fields
  function automatic logic [31:0] ctrl_word(input irq_prio_pkg::ctrl_type c);
    logic [31:0] w;
    w = '0;
    w[irq_prio_pkg::CTRL_ROT_BIT]  = c.rotate;
    w[irq_prio_pkg::CTRL_CVT_BIT]  = c.compact;
    w[irq_prio_pkg::CTRL_BASE_BIT] = c.base_sel;
    return w;
  endfunction

  function automatic logic [31:0] status_word(input irq_prio_pkg::status_type s);
    logic [31:0] w;
    w = '0;
    w[irq_prio_pkg::STAT_L0_BIT]  = s.l0_ex;
    w[irq_prio_pkg::STAT_L1_BIT]  = s.l1_ex;
    w[irq_prio_pkg::STAT_NMI_BIT] = s.nmi_ex;
    return w;
  endfunction

  always_comb begin
    nxt_state = state_ff;
    access    = psel && penable;
    idx       = paddr[3:2];
    addr_ok   = paddr[irq_prio_pkg::PADDR_W-1:4] == '0 && paddr[1:0] == 2'h0;

    // APB slave: one wait state, answer from registers
    nxt_state.ready = 1'b0;
    nxt_state.err   = 1'b0;
    if (access && !state_ff.ready) begin
      nxt_state.ready = 1'b1;
      nxt_state.err   = !addr_ok;
      nxt_state.rdata = '0;
      if (addr_ok && !pwrite) begin
        case (idx)
          irq_prio_pkg::IDX_CTRL:   nxt_state.rdata = ctrl_word(state_ff.ctrl);
          irq_prio_pkg::IDX_STATUS: nxt_state.rdata = status_word(state_ff.status);
          irq_prio_pkg::IDX_PRI:    nxt_state.rdata = 32'(state_ff.last_l0);
          irq_prio_pkg::IDX_L1VEC:  nxt_state.rdata = 32'(state_ff.l1_vec);
          default:                  nxt_state.rdata = '0;
        endcase
      end
    end

    // Writes take effect at the completing edge; status is read-only
    if (access && state_ff.ready && pwrite && addr_ok) begin
      case (idx)
        irq_prio_pkg::IDX_CTRL: begin
          nxt_state.ctrl.rotate   = pwdata[irq_prio_pkg::CTRL_ROT_BIT];
          nxt_state.ctrl.compact  = pwdata[irq_prio_pkg::CTRL_CVT_BIT];
          nxt_state.ctrl.base_sel = pwdata[irq_prio_pkg::CTRL_BASE_BIT];
        end
        irq_prio_pkg::IDX_PRI:   nxt_state.last_l0 = pwdata[irq_prio_pkg::VEC_W-1:0];
        irq_prio_pkg::IDX_L1VEC: nxt_state.l1_vec = pwdata[irq_prio_pkg::VEC_W-1:0];
        default: ;
      endcase
    end

    // Pulses last one cycle
    nxt_state.ack  = 1'b0;
    nxt_state.load = 1'b0;

    // Halted core freezes the sequencer and level flags; APB register writes still take effect
    if (!debug_halt) begin
      case (state_ff.seq)
        SEQ_IDLE: begin
          if (return_from_handler) begin
            // Highest active level only; no saved copy exists
            if (state_ff.status.nmi_ex) begin
              nxt_state.status.nmi_ex = 1'b0;
            end else if (state_ff.status.l1_ex) begin
              nxt_state.status.l1_ex = 1'b0;
            end else begin
              nxt_state.status.l0_ex = 1'b0;
            end
            nxt_state.gap_ok = 1'b0;
          end else if (instr_done) begin
            if (pick.valid && state_ff.gap_ok) begin
              nxt_state.ack      = 1'b1;
              nxt_state.ack_vec  = pick.vec;
              nxt_state.vec_addr = pick_addr;
              nxt_state.gap_ok   = 1'b0;
              nxt_state.stall    = 1'b1;
              nxt_state.push_cnt = irq_prio_pkg::PUSH_CYCLES;
              nxt_state.seq      = SEQ_PUSH;
              // Only the level flag changes, plus last_l0 for level 0; global enable is untouched
              case (pick.lvl)
                irq_prio_pkg::LVL_NMI: nxt_state.status.nmi_ex = 1'b1;
                irq_prio_pkg::LVL_1:   nxt_state.status.l1_ex = 1'b1;
                default: begin
                  nxt_state.status.l0_ex = 1'b1;
                  nxt_state.last_l0      = pick.vec;
                end
              endcase
            end else begin
              nxt_state.gap_ok = 1'b1;
            end
          end
        end
        SEQ_PUSH: begin
          // Core stores its program counter during these cycles
          nxt_state.push_cnt = state_ff.push_cnt - 2'h1;
          if (state_ff.push_cnt == 2'h1) begin
            nxt_state.seq = SEQ_LOAD;
          end
        end
        SEQ_LOAD: begin
          nxt_state.load  = 1'b1;
          nxt_state.stall = 1'b0;
          nxt_state.seq   = SEQ_IDLE;
        end
        default: begin
          nxt_state.seq   = SEQ_IDLE;
          nxt_state.stall = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff          <= '0;
      state_ff.seq      <= SEQ_IDLE;
      state_ff.ctrl     <= irq_prio_pkg::ctrl_type'(3'h0);
      state_ff.l1_vec   <= irq_prio_pkg::L1VEC_RST[irq_prio_pkg::VEC_W-1:0];
      state_ff.last_l0  <= irq_prio_pkg::PRI_RST[irq_prio_pkg::VEC_W-1:0];
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Reset entry is fixed regardless of base placement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_addr <= irq_prio_pkg::RESET_ADDR;
    end else begin
      reset_addr <= irq_prio_pkg::RESET_ADDR;
    end
  end

  always_comb begin
    prdata         = state_ff.rdata;
    pready         = state_ff.ready;
    pslverr        = state_ff.err;
    irq_ack        = state_ff.ack;
    ack_vector     = state_ff.ack_vec;
    core_stall     = state_ff.stall;
    pc_load        = state_ff.load;
    pc_vector_addr = state_ff.vec_addr;
    nmi_executing  = state_ff.status.nmi_ex;
    high_executing = state_ff.status.l1_ex;
    low_executing  = state_ff.status.l0_ex;
  end

endmodule

// *** sim/irq_prio_properties.sv ***
// Concurrent checks on the prioritizer's core-side ports.
// Assumes a single pclk domain; bound into every prioritizer instance.
`timescale 1ns/10ps
module irq_prio_properties (
  input wire logic                             pclk,
  input wire logic                             presetn,
  input wire logic                             global_int_enable,
  input wire logic                             instr_done,
  input wire logic                             return_from_handler,
  input wire logic                             debug_halt,
  input wire logic                             irq_ack,
  input wire logic [irq_prio_pkg::VEC_W-1:0]   ack_vector,
  input wire logic                             core_stall,
  input wire logic                             pc_load,
  input wire logic [irq_prio_pkg::ADDR_W-1:0]  reset_addr,
  input wire logic                             nmi_executing,
  input wire logic                             high_executing,
  input wire logic                             low_executing
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Stall for three cycles (the two push cycles and the load state), then one load strobe
  sequence push_s;
    core_stall [*3] ##1 (pc_load && !core_stall);
  endsequence
  chk_push_span: assert property (irq_ack |-> push_s)
    else $error("push sequence wrong");
  chk_ack_source: assert property (irq_ack |-> $past(instr_done) && !$past(return_from_handler))
    else $error("ack without finished instruction");
  chk_ack_spacing: assert property (irq_ack |=> !irq_ack [*4])
    else $error("acks too close");
  chk_mask_gie: assert property (irq_ack && !$past(global_int_enable) |-> ack_vector == 5'h01)
    else $error("maskable ack with enable low");
  chk_high_blocks: assert property (irq_ack && $past(high_executing) |-> ack_vector == 5'h01)
    else $error("level 1 handler preempted");
  chk_nmi_blocks: assert property (irq_ack |-> !$past(nmi_executing))
    else $error("non-maskable handler preempted");
  chk_nmi_flag: assert property (irq_ack && ack_vector == 5'h01 |-> nmi_executing)
    else $error("non-maskable flag not set");
  chk_ret_nmi: assert property (return_from_handler && !debug_halt && nmi_executing
    |=> !nmi_executing && high_executing == $past(high_executing))
    else $error("return from non-maskable wrong");
  chk_ret_high: assert property (return_from_handler && !debug_halt && !nmi_executing && high_executing
    |=> !high_executing && low_executing == $past(low_executing))
    else $error("return from level 1 wrong");
  chk_halt_freeze: assert property (debug_halt |=> !irq_ack && $stable({nmi_executing, high_executing, low_executing}))
    else $error("state moved while halted");
  chk_reset_addr: assert property (reset_addr == irq_prio_pkg::RESET_ADDR)
    else $error("reset address wrong");
endmodule

bind cpu_interrupt_prioritizer irq_prio_properties u_props (
  .pclk(pclk), .presetn(presetn), .global_int_enable(global_int_enable), .instr_done(instr_done),
  .return_from_handler(return_from_handler), .debug_halt(debug_halt), .irq_ack(irq_ack),
  .ack_vector(ack_vector), .core_stall(core_stall), .pc_load(pc_load), .reset_addr(reset_addr),
  .nmi_executing(nmi_executing), .high_executing(high_executing), .low_executing(low_executing));

// *** sim/core_model.sv ***
// Core stand-in: ends instructions, obeys the stall, issues returns.
// Assumes stall and load strobes come straight from the prioritizer.
`timescale 1ns/10ps
module core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic core_stall,
  input  wire logic pc_load,
  input  wire logic ret_req,
  input  wire logic multi,
  output logic      instr_done,
  output logic      return_from_handler
);
  logic [1:0] jump_ff;
  logic [1:0] phase_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jump_ff             <= 2'h0;
      phase_ff            <= 2'h0;
      instr_done          <= 1'b0;
      return_from_handler <= 1'b0;
    end else begin
      if (pc_load)
        jump_ff <= 2'h3;
      else if (jump_ff != 2'h0)
        jump_ff <= jump_ff - 2'h1;
      phase_ff <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
      // Multicycle mode ends an instruction only every third cycle
      instr_done <= !core_stall && !pc_load && jump_ff <= 2'h1 && (!multi || phase_ff == 2'h2);
      return_from_handler <= ret_req && !core_stall;
    end
  end
endmodule

// *** sim/cpu_interrupt_prioritizer_test.sv ***
// Directed bench: APB set-up, peripheral requests, core model returns.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module cpu_interrupt_prioritizer_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        gie, debug_halt, ret_req, multi, instr_done, ret, irq_ack, core_stall, pc_load;
  logic        nmi_ex, high_ex, low_ex;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, irq_req;
  logic [15:0] app_start, pc_vector_addr, reset_addr;
  logic [4:0]  ack_vector;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          ack_cnt = 0;
  int          cycles = 0;

  cpu_interrupt_prioritizer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req), .global_int_enable(gie), .instr_done(instr_done), .return_from_handler(ret),
    .debug_halt(debug_halt), .app_start_addr(app_start), .irq_ack(irq_ack), .ack_vector(ack_vector),
    .core_stall(core_stall), .pc_load(pc_load), .pc_vector_addr(pc_vector_addr), .reset_addr(reset_addr),
    .nmi_executing(nmi_ex), .high_executing(high_ex), .low_executing(low_ex));
  core_model u_core (.pclk(pclk), .presetn(presetn), .core_stall(core_stall), .pc_load(pc_load),
    .ret_req(ret_req), .multi(multi), .instr_done(instr_done), .return_from_handler(ret));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Counted mid-cycle so readers after an edge never race it
  always @(negedge pclk) if (irq_ack === 1'b1) ack_cnt++;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test;
    end
  end

  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task take(input logic [4:0] v, input logic [15:0] a);
    int n;
    n = 0;
    while (irq_ack !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    check("ack seen", 32'(irq_ack), 32'h1);
    check("ack vector", 32'(ack_vector), 32'(v));
    n = 0;
    while (pc_load !== 1'b1 && n < 9) begin
      @(posedge pclk);
      n++;
    end
    check("push cycles", n, 3);
    check("vector address", 32'(pc_vector_addr), 32'(a));
  endtask
  task ret_h;
    ret_req <= 1'b1;
    @(posedge pclk);
    ret_req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task quiet(input string what);
    int c;
    c = ack_cnt;
    repeat (10) @(posedge pclk);
    check(what, ack_cnt, c);
  endtask
  function automatic logic [15:0] va(input logic [4:0] v, input logic boot);
    return (boot ? 16'h0000 : app_start) + irq_prio_pkg::VEC_OFFSET + (16'(v) << irq_prio_pkg::VEC_SLOT_SH);
  endfunction

  initial begin
    {presetn, psel, penable, pwrite, gie, debug_halt, ret_req, multi} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq_req = 32'h0;
    app_start = 16'h0100;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    check("unmapped error", 32'(err), 32'h1);
    apb(1'b1, 12'h004, 32'h0000_0083);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      check("register reset", rd, 32'h0);
    end
    check("reset address", 32'(reset_addr), 32'h0);
    $display("test reset done");
    gie <= 1'b1;
    irq_req <= 32'h0000_0028;
    take(5'h03, va(5'h03, 1'b0));
    check("low flag", 32'(low_ex), 32'h1);
    irq_req <= 32'h0000_0020;
    quiet("pending level 0");
    ret_h;
    take(5'h05, va(5'h05, 1'b0));
    apb(1'b1, 12'h00c, 32'h0000_0007);
    irq_req <= 32'h0000_00a0;
    take(5'h07, va(5'h07, 1'b0));
    check("nested flags", 32'({high_ex, low_ex}), 32'h3);
    // Non-maskable on top of both levels; its line drops before the return
    irq_req <= 32'h0000_0022;
    take(5'h01, va(5'h01, 1'b0));
    check("three deep", 32'({nmi_ex, high_ex, low_ex}), 32'h7);
    irq_req <= 32'h0000_0020;
    ret_h;
    check("level 1 resumes", 32'({nmi_ex, high_ex, low_ex}), 32'h3);
    ret_h;
    check("level 0 resumes", 32'({nmi_ex, high_ex, low_ex}), 32'h1);
    irq_req <= 32'h0;
    ret_h;
    check("all idle", 32'({nmi_ex, high_ex, low_ex}), 32'h0);
    $display("test levels done");
    gie <= 1'b0;
    irq_req <= 32'h0000_0012;
    take(5'h01, va(5'h01, 1'b0));
    irq_req <= 32'h0000_0010;
    ret_h;
    check("nmi cleared", 32'(nmi_ex), 32'h0);
    quiet("masked request");
    debug_halt <= 1'b1;
    gie <= 1'b1;
    quiet("halted");
    debug_halt <= 1'b0;
    take(5'h04, va(5'h04, 1'b0));
    irq_req <= 32'h0;
    ret_h;
    $display("test nmi and halt done");
    apb(1'b1, 12'h000, 32'h0000_0061);
    apb(1'b0, 12'h000, 32'h0);
    check("control", rd, 32'h0000_0061);
    multi <= 1'b1;
    irq_req <= 32'h0000_00a8;
    take(5'h07, va(irq_prio_pkg::CVT_L1_VEC, 1'b1));
    irq_req <= 32'h0000_0028;
    ret_h;
    take(5'h05, va(irq_prio_pkg::CVT_L0_VEC, 1'b1));
    ret_h;
    take(5'h03, va(irq_prio_pkg::CVT_L0_VEC, 1'b1));
    apb(1'b0, 12'h008, 32'h0);
    check("rotate pointer", rd, 32'h0000_0003);
    irq_req <= 32'h0;
    // Mid-run reset while a level 0 handler runs with rotation and compact set
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("flags after reset", 32'({nmi_ex, high_ex, low_ex}), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    check("control after reset", rd, 32'h0);
    ret_h;
    $display("test rotation done");
    end_of_test;
  end
endmodule
